/* File: verilog/pxc_defines.vh */
// Purpose: constants for the extended control register block
// Assumes: 16-bit management register, one clock
// Notes: definitions only
`ifndef PXC_DEFINES_VH
`define PXC_DEFINES_VH
`define PXC_REG_ADDR 5'h13
`define PXC_BIT_NODE 15
`define PXC_BIT_SWMODE 14
`define PXC_BIT_RFAULT 13
`define PXC_BIT_AUTO_EN 9
`define PXC_BIT_FORCE_SEL 8
`define PXC_BIT_HIZ 7
`define PXC_BIT_APD 0
`define PXC_RST_VALUE 16'h4201
`define PXC_RW_MASK 16'h1BFF
`define PXC_NODE_VALUE 1'h0
`define PXC_SWMODE_VALUE 1'h1
`define PXC_SWAP_HOLD 16'h0FA0
`define PXC_SWAP_HOLD_W 16
`endif

/* File: verilog/pxc_pair_mux.v */
// Purpose: steer transmit/receive onto pair a or pair b
// Assumes: crossed_i selects the crossed assignment
// Notes: hi-z held by enables low
`timescale 1ns/100ps
module pxc_pair_mux (
  input wire clk_i,
  input wire reset_i,
  input wire crossed_i,
  input wire hiz_i,
  input wire tx_p_i,
  input wire tx_n_i,
  input wire pair_a_positive_i,
  input wire pair_a_negative_i,
  input wire pair_b_positive_i,
  input wire pair_b_negative_i,
  output reg pair_a_positive_o,
  output reg pair_a_negative_o,
  output reg pair_a_oe_o,
  output reg pair_b_positive_o,
  output reg pair_b_negative_o,
  output reg pair_b_oe_o,
  output reg rx_p_o,
  output reg rx_n_o
);
  always @(posedge clk_i) begin
    if (reset_i) begin
      pair_a_positive_o <= 1'b0;
      pair_a_negative_o <= 1'b0;
      pair_b_positive_o <= 1'b0;
      pair_b_negative_o <= 1'b0;
      pair_a_oe_o <= 1'b0;
      pair_b_oe_o <= 1'b0;
      rx_p_o <= 1'b0;
      rx_n_o <= 1'b0;
    end else begin
      pair_a_positive_o <= tx_p_i;
      pair_a_negative_o <= tx_n_i;
      pair_b_positive_o <= tx_p_i;
      pair_b_negative_o <= tx_n_i;
      pair_a_oe_o <= ~hiz_i & ~crossed_i;
      pair_b_oe_o <= ~hiz_i & crossed_i;
      rx_p_o <= crossed_i ? pair_a_positive_i : pair_b_positive_i;
      rx_n_o <= crossed_i ? pair_a_negative_i : pair_b_negative_i;
    end
  end
endmodule

/* File: verilog/pxc_auto_cross.v */
// Purpose: automatic straight/crossed selection
// Assumes: link_ok_i high while a link is seen on the current pairs
// Notes: swaps after a hold count without link
`timescale 1ns/100ps
`include "pxc_defines.vh"
module pxc_auto_cross #(
  parameter HOLD = `PXC_SWAP_HOLD
) (
  input wire clk_i,
  input wire reset_i,
  input wire enable_i,
  input wire link_ok_i,
  output reg crossed_o
);
  reg [`PXC_SWAP_HOLD_W-1:0] count;
  always @(posedge clk_i) begin
    if (reset_i) begin
      count <= 16'h0000;
      crossed_o <= 1'b0;
    end else if (!enable_i || link_ok_i) begin
      count <= 16'h0000;
    end else if (count == HOLD[`PXC_SWAP_HOLD_W-1:0]) begin
      // no link on this assignment, try the other one
      count <= 16'h0000;
      crossed_o <= ~crossed_o;
    end else begin
      count <= count + 16'h0001;
    end
  end
endmodule

/* File: verilog/pxc_ext_control.v */
// Purpose: extended control register 13h with pair crossover control
// Assumes: management access already decoded into 5-bit address and strobes
// Notes: inputs synchronous to clk_i
// Function
// - node/repeater bit reads zero; node configuration only.
// - carrier sense asserted on transmit or receive activity.
// - signal quality error test enabled by default in node mode.
// - hardware/software bit reads one; register bits control configuration.
// - remote fault bit follows link partner's fault report.
// - register enable zero: pin ignored, force-select picks straight or crossed.
// - pin low with register enable one forces straight.
// - pin and register enable both one: automatic crossover selection.
// - straight sends on pair a; crossed sends on pair b.
// - reset: crossover enable one, force-select zero.
// - tri-state bit one puts pair outputs in high impedance; resets zero.
// - auto power-down bit with 10 Mb/s operation turns off 100 Mb/s transceiver.
// - isolate also powers down the 100 Mb/s transceiver.
// - crossover controls at bits 9 and 8 of register 13h.
`timescale 1ns/100ps
`include "pxc_defines.vh"
module pxc_ext_control #(
  parameter SWAP_HOLD = `PXC_SWAP_HOLD
) (
  input wire clk_i,
  input wire reset_i,
  input wire [4:0] reg_addr_i,
  input wire reg_write_i,
  input wire reg_read_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  input wire crossover_auto_enable_i,
  input wire link_ok_i,
  input wire partner_fault_i,
  input wire speed_10_i,
  input wire isolate_i,
  input wire tx_active_i,
  input wire rx_active_i,
  input wire twisted_transmit_positive_i,
  input wire twisted_transmit_negative_i,
  input wire pair_a_positive_i,
  input wire pair_a_negative_i,
  input wire pair_b_positive_i,
  input wire pair_b_negative_i,
  output wire pair_a_positive_o,
  output wire pair_a_negative_o,
  output wire pair_a_oe_o,
  output wire pair_b_positive_o,
  output wire pair_b_negative_o,
  output wire pair_b_oe_o,
  output wire rx_p_o,
  output wire rx_n_o,
  output reg crossed_o,
  output reg carrier_sense_o,
  output reg sqe_test_enable_o,
  output reg tx100_power_down_o
);
  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  reg [15:0] ctrl;
  reg remote_fault;
  wire hit;
  wire auto_cross;
  reg next_crossed;
  wire [15:0] read_value;

  assign hit = (reg_addr_i == `PXC_REG_ADDR);

  always @(posedge clk_i) begin
    if (reset_i) begin
      ctrl <= `PXC_RST_VALUE;
    end else if (reg_write_i && hit) begin
      // read-only bits are kept; reserved writable bits take what is written
      ctrl <= (reg_wdata_i & `PXC_RW_MASK) | (ctrl & ~`PXC_RW_MASK);
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      remote_fault <= 1'b0;
    end else begin
      remote_fault <= partner_fault_i;
    end
  end

  function [15:0] pxc_compose;
    input [15:0] c;
    input rf;
    begin
      pxc_compose = c;
      pxc_compose[`PXC_BIT_NODE] = `PXC_NODE_VALUE;
      pxc_compose[`PXC_BIT_SWMODE] = `PXC_SWMODE_VALUE;
      pxc_compose[`PXC_BIT_RFAULT] = rf;
    end
  endfunction

  assign read_value = pxc_compose(ctrl, remote_fault);

  always @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_read_i) begin
      reg_rdata_o <= hit ? read_value : 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // crossover selection
  // ------------------------------------------------------------
  pxc_auto_cross #(
    .HOLD(SWAP_HOLD)
  ) u_auto (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(ctrl[`PXC_BIT_AUTO_EN] & crossover_auto_enable_i),
    .link_ok_i(link_ok_i),
    .crossed_o(auto_cross)
  );

  always @* begin
    if (!ctrl[`PXC_BIT_AUTO_EN]) begin
      next_crossed = ctrl[`PXC_BIT_FORCE_SEL];
    end else if (!crossover_auto_enable_i) begin
      next_crossed = 1'b0;
    end else begin
      next_crossed = auto_cross;
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      crossed_o <= 1'b0;
      carrier_sense_o <= 1'b0;
      sqe_test_enable_o <= 1'b1;
      tx100_power_down_o <= 1'b0;
    end else begin
      crossed_o <= next_crossed;
      carrier_sense_o <= tx_active_i | rx_active_i;
      sqe_test_enable_o <= 1'b1;
      tx100_power_down_o <= (ctrl[`PXC_BIT_APD] & speed_10_i) | isolate_i;
    end
  end

  // ------------------------------------------------------------
  // pair switching
  // ------------------------------------------------------------
  pxc_pair_mux u_mux (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .crossed_i(next_crossed),
    .hiz_i(ctrl[`PXC_BIT_HIZ]),
    .tx_p_i(twisted_transmit_positive_i),
    .tx_n_i(twisted_transmit_negative_i),
    .pair_a_positive_i(pair_a_positive_i),
    .pair_a_negative_i(pair_a_negative_i),
    .pair_b_positive_i(pair_b_positive_i),
    .pair_b_negative_i(pair_b_negative_i),
    .pair_a_positive_o(pair_a_positive_o),
    .pair_a_negative_o(pair_a_negative_o),
    .pair_a_oe_o(pair_a_oe_o),
    .pair_b_positive_o(pair_b_positive_o),
    .pair_b_negative_o(pair_b_negative_o),
    .pair_b_oe_o(pair_b_oe_o),
    .rx_p_o(rx_p_o),
    .rx_n_o(rx_n_o)
  );
endmodule

/* File: verif/pxc_cable_model.sv */
// Purpose: cable seen from the pair side
// Assumes: link only when pairs line up with the cable
// Notes: one cycle of lag, like a real link detect
`timescale 1ns/100ps
module pxc_cable_model (
  input wire clk_i,
  input wire crossed_i,
  input wire cable_crossed_i,
  output reg link_ok_o
);
  initial link_ok_o = 1'b0;
  always @(posedge clk_i) begin
    link_ok_o <= crossed_i == cable_crossed_i;
  end
endmodule

/* File: verif/pxc_ext_control_chk.sv */
// Purpose: port checks for pxc_ext_control
// Assumes: one clock, sync reset
// Notes: bound after the module
`timescale 1ns/100ps
module pxc_ext_control_chk (
  input wire clk_i,
  input wire reset_i,
  input wire [4:0] reg_addr_i,
  input wire reg_read_i,
  input wire [15:0] reg_rdata_o,
  input wire isolate_i,
  input wire tx_active_i,
  input wire rx_active_i,
  input wire pair_b_positive_i,
  input wire twisted_transmit_positive_i,
  input wire twisted_transmit_negative_i,
  input wire pair_a_positive_i,
  input wire pair_a_negative_i,
  input wire pair_b_negative_i,
  input wire partner_fault_i,
  input wire pair_a_positive_o,
  input wire pair_a_negative_o,
  input wire pair_b_positive_o,
  input wire pair_b_negative_o,
  input wire rx_n_o,
  input wire pair_a_oe_o,
  input wire pair_b_oe_o,
  input wire rx_p_o,
  input wire crossed_o,
  input wire carrier_sense_o,
  input wire sqe_test_enable_o,
  input wire tx100_power_down_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_id; reg_read_i && reg_addr_i == 5'h13 |=> reg_rdata_o[15:14] == 2'h1; endproperty
  a_id: assert property (p_id) else $error("id bits wrong");
  property p_cs; tx_active_i || rx_active_i |=> carrier_sense_o; endproperty
  a_cs: assert property (p_cs) else $error("carrier missing");
  property p_sqe; sqe_test_enable_o; endproperty
  a_sqe: assert property (p_sqe) else $error("sqe off");
  property p_iso; isolate_i |=> tx100_power_down_o; endproperty
  a_iso: assert property (p_iso) else $error("no power down");
  property p_pa; pair_a_oe_o |-> !crossed_o && !pair_b_oe_o; endproperty
  a_pa: assert property (p_pa) else $error("pair a bad");
  property p_pb; pair_b_oe_o |-> crossed_o; endproperty
  a_pb: assert property (p_pb) else $error("pair b bad");
  property p_rx; !crossed_o && !$past(reset_i) |-> rx_p_o == $past(pair_b_positive_i) &&
    rx_n_o == $past(pair_b_negative_i); endproperty
  a_rx: assert property (p_rx) else $error("rx pair bad");
  property p_rxc; crossed_o && !$past(reset_i) |-> rx_p_o == $past(pair_a_positive_i) &&
    rx_n_o == $past(pair_a_negative_i); endproperty
  a_rxc: assert property (p_rxc) else $error("crossed rx pair bad");
  property p_tx; !$past(reset_i) |-> pair_a_positive_o == $past(twisted_transmit_positive_i) &&
    pair_a_negative_o == $past(twisted_transmit_negative_i) && pair_b_positive_o == $past(twisted_transmit_positive_i) &&
    pair_b_negative_o == $past(twisted_transmit_negative_i); endproperty
  a_tx: assert property (p_tx) else $error("tx data bad");
  property p_cs0; !tx_active_i && !rx_active_i |=> !carrier_sense_o; endproperty
  a_cs0: assert property (p_cs0) else $error("carrier without activity");
  property p_rf; reg_read_i && reg_addr_i == 5'h13 && !$past(reset_i) |=>
    reg_rdata_o[13] == $past(partner_fault_i, 2); endproperty
  a_rf: assert property (p_rf) else $error("remote fault bit bad");
  property p_map; reg_read_i && reg_addr_i != 5'h13 |=> reg_rdata_o == 16'h0000; endproperty
  a_map: assert property (p_map) else $error("unmapped read");
endmodule
bind pxc_ext_control pxc_ext_control_chk u_chk (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .isolate_i(isolate_i), .tx_active_i(tx_active_i),
  .rx_active_i(rx_active_i), .pair_b_positive_i(pair_b_positive_i),
  .twisted_transmit_positive_i(twisted_transmit_positive_i), .twisted_transmit_negative_i(twisted_transmit_negative_i),
  .pair_a_positive_i(pair_a_positive_i), .pair_a_negative_i(pair_a_negative_i), .pair_b_negative_i(pair_b_negative_i),
  .partner_fault_i(partner_fault_i), .pair_a_positive_o(pair_a_positive_o), .pair_a_negative_o(pair_a_negative_o),
  .pair_b_positive_o(pair_b_positive_o), .pair_b_negative_o(pair_b_negative_o), .rx_n_o(rx_n_o),
  .pair_a_oe_o(pair_a_oe_o),
  .pair_b_oe_o(pair_b_oe_o), .rx_p_o(rx_p_o), .crossed_o(crossed_o), .carrier_sense_o(carrier_sense_o),
  .sqe_test_enable_o(sqe_test_enable_o), .tx100_power_down_o(tx100_power_down_o));

/* File: verif/pxc_ext_control_bench.sv */
// Purpose: register and pin tests for pxc_ext_control
// Assumes: reserved bits always written as zero
// Notes: short swap hold keeps the auto case quick
`timescale 1ns/100ps
module pxc_ext_control_bench;
  reg clk_i = 0, reset_i = 1, wr_s = 0, rd_s = 0, tog = 0;
  reg pin = 1, flt = 0, spd = 0, iso = 0, cab = 0;
  reg [4:0] addr = 5'h13;
  reg [15:0] wd = 16'h0000;
  wire link, crossed, pa_oe, pb_oe, pd;
  wire [15:0] rdata;
  integer n_mismatch = 0, checks_done = 0, i;
  always #12.5 clk_i = ~clk_i;
  always @(negedge clk_i) tog <= ~tog;
  pxc_ext_control #(.SWAP_HOLD(8)) u_pxc_ext_control (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr),
    .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_wdata_i(wd), .reg_rdata_o(rdata), .crossover_auto_enable_i(pin),
    .link_ok_i(link), .partner_fault_i(flt), .speed_10_i(spd), .isolate_i(iso), .tx_active_i(tog),
    .rx_active_i(~tog & ~iso), .twisted_transmit_positive_i(tog), .twisted_transmit_negative_i(~tog),
    .pair_a_positive_i(~tog), .pair_a_negative_i(tog), .pair_b_positive_i(tog), .pair_b_negative_i(~tog),
    .pair_a_positive_o(), .pair_a_negative_o(), .pair_a_oe_o(pa_oe), .pair_b_positive_o(),
    .pair_b_negative_o(), .pair_b_oe_o(pb_oe), .rx_p_o(), .rx_n_o(), .crossed_o(crossed),
    .carrier_sense_o(), .sqe_test_enable_o(), .tx100_power_down_o(pd));
  pxc_cable_model u_pxc_cable_model (.clk_i(clk_i), .crossed_i(crossed), .cable_crossed_i(cab), .link_ok_o(link));
  task chk(input [15:0] seen, input [15:0] exp); begin
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  end endtask
  task wr(input [4:0] a, input [15:0] d); begin
    @(negedge clk_i); addr = a; wd = d; wr_s = 1;
    @(negedge clk_i); wr_s = 0;
  end endtask
  task rd(input [4:0] a, input [15:0] exp); begin
    @(negedge clk_i); addr = a; rd_s = 1;
    @(negedge clk_i); rd_s = 0;
    chk(rdata, exp);
  end endtask
  task stop_test; begin
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end endtask
  initial begin
    repeat (3) @(negedge clk_i);
    reset_i = 0;
    rd(5'h13, 16'h4201);
    wr(5'h12, 16'h0000);
    rd(5'h12, 16'h0000);
    rd(5'h13, 16'h4201);
    for (i = 0; i < 8; i = i + 1) begin
      pin = i[2];
      wr(5'h13, {6'h00, i[1:0], 8'h00});
      repeat (3) @(negedge clk_i);
      chk(crossed, i[1] ? 1'b0 : i[0]);
      chk(pb_oe, i[1] ? 1'b0 : i[0]);
    end
    cab = 1;
    for (i = 0; i < 60 && crossed !== 1'b1; i = i + 1) @(negedge clk_i);
    chk(crossed, 1'b1);
    if (i == 60) stop_test;
    wr(5'h13, 16'h0000);
    repeat (3) @(negedge clk_i);
    chk({pa_oe, pb_oe}, 2'h2);
    wr(5'h13, 16'h0080);
    repeat (3) @(negedge clk_i);
    chk({pa_oe, pb_oe}, 2'h0);
    for (i = 0; i < 4; i = i + 1) begin
      spd = i[1];
      wr(5'h13, {15'h0000, i[0]});
      repeat (3) @(negedge clk_i);
      chk(pd, i[0] & i[1]);
    end
    spd = 0;
    iso = 1;
    flt = 1;
    repeat (3) @(negedge clk_i);
    chk(pd, 1'b1);
    rd(5'h13, 16'h6001);
    stop_test;
  end
endmodule
